// ===== logic/vpsp_pkg.sv
// Shared constants and carrier types for the voice processor slave port.
// Assumes a single 25 MHz system clock and a synchronous active-high reset.
package vpsp_pkg;

  // System clock
  localparam int CLK_PERIOD_NS = 40;

  // Port widths
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int NIB_W  = 4;

  // Rate buffer geometry: 36 nibbles, circular
  localparam int          BUF_DEPTH = 36;
  localparam int          PTR_W     = 6;
  localparam logic [5:0]  PTR_LAST  = 6'h23;
  localparam logic [5:0]  PTR_RST   = 6'h00;

  // Port address map: location 0 is the voice nibble pipe
  localparam logic [2:0]  ADDR_VOICE = 3'h0;
  localparam logic [7:0]  RD_IDLE_VAL = 8'h00;

  // Read data must stand on the bus this long before ready falls
  localparam int RD_SETUP_NS  = 22;
  localparam int RD_SETUP_CYC = (RD_SETUP_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;

  // Processor clock output: half period in system clocks
  localparam logic [3:0]  VOICE_PROC_CLK_OUT_HALF = 4'h1;

  // Strobe synchroniser and data alignment depth
  localparam int SYNC_STAGES = 3;

  // Access state machine
  typedef enum logic [2:0] {
    VPSP_IDLE   = 3'b000,
    VPSP_FETCH  = 3'b001,
    VPSP_DRIVE  = 3'b010,
    VPSP_ACK_RD = 3'b011,
    VPSP_ACK_WR = 3'b100
  } vpsp_state_e;

  // One sampled processor request
  typedef struct packed {
    logic [2:0] addr;
    logic       rnw;
    logic [7:0] data;
  } vpsp_req_s;

endpackage

// ===== logic/vpsp_nibble_ram.sv
// Small nibble memory for one rate buffer, one write and one read port.
// Assumes the caller keeps addresses below the depth; read data registered.
`timescale 1ns/100ps
module vpsp_nibble_ram (
  // Clock
  input  wire logic                      i_clk,
  // Write port
  input  wire logic                      i_wr_en,
  input  wire logic [vpsp_pkg::PTR_W-1:0] i_wr_addr,
  input  wire logic [vpsp_pkg::NIB_W-1:0] i_wr_data,
  // Read port
  input  wire logic                      i_rd_en,
  input  wire logic [vpsp_pkg::PTR_W-1:0] i_rd_addr,
  output logic      [vpsp_pkg::NIB_W-1:0] o_rd_data
);
  import vpsp_pkg::*;

  logic [NIB_W-1:0] mem_r [BUF_DEPTH];

  // Storage, no reset so it maps onto plain memory cells
  always_ff @(posedge i_clk) begin
    if (i_wr_en) begin
      mem_r[i_wr_addr] <= i_wr_data;
    end
  end

  // Registered read, old data on a same-address collision
  always_ff @(posedge i_clk) begin
    if (i_rd_en) begin
      o_rd_data <= mem_r[i_rd_addr];
    end
  end

endmodule

// ===== logic/vpsp_port.sv
// Voice processor slave port: parallel strobe bus into two rate buffers.
// Assumes pins are sampled on i_clk; the bus wire is resolved outside.
// How it works
// (RULE_01) Slave only; never starts a transfer.
// (RULE_02) Address, data, strobe, direction in; ready out.
// (RULE_03) Three-bit address is an input only.
// (RULE_04) Eight-bit data: we drive on reads.
// (RULE_05) Read when direction reads during strobe.
// (RULE_06) Write when direction writes during strobe.
// (RULE_07) Address and direction stable around strobe.
// (RULE_08) Write data taken at strobe rising edge.
// (RULE_09) Ready active low; high means wait.
// (RULE_10) Read data valid before ready falls.
// (RULE_11) Processor holds strobe until ready falls.
// (RULE_12) Processor reads always with a wait.
// (RULE_13) No write right after a read.
// (RULE_14) Clock output derived from master clock.
// (RULE_15) External reset held eighteen master clocks; the bench holds it ten at start, 28 mid-run.
// (RULE_16) Received nibbles handed out in order.
// (RULE_17) Transmit side is one sequential pipe.
// (RULE_18) Buffers hold 36 nibbles, wrapping circularly.
// (RULE_19) Drive data only during read strobe.
// (RULE_20) Synchronise strobe before acting on it.
`timescale 1ns/100ps
module vpsp_port (
  // Clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_srst,
  // Processor bus pins
  input  wire logic [vpsp_pkg::ADDR_W-1:0] i_voice_port_addr,
  input  wire logic [vpsp_pkg::DATA_W-1:0] i_voice_port_data,
  input  wire logic                       i_voice_port_strobe_n,
  input  wire logic                       i_voice_port_read_write,
  output logic      [vpsp_pkg::DATA_W-1:0] o_voice_port_data,
  output logic                            o_voice_port_data_oe_n,
  output logic                            o_voice_port_ready_n,
  output logic                            o_voice_proc_clk_out,
  // Received nibbles from the demodulator
  input  wire logic                       i_rx_nib_valid,
  input  wire logic [vpsp_pkg::NIB_W-1:0]  i_rx_nib,
  // Transmit nibbles to the modulator
  output logic                            o_tx_nib_valid,
  output logic      [vpsp_pkg::NIB_W-1:0]  o_tx_nib,
  input  wire logic                       i_tx_nib_ready
);
  import vpsp_pkg::*;

  // Circular pointer step, shared by all four pointers
  function automatic logic [PTR_W-1:0] next_ptr(input logic [PTR_W-1:0] p);
    next_ptr = (p == PTR_LAST) ? PTR_RST : p + 6'h01; // [RULE_18]
  endfunction

  vpsp_state_e      st_r;
  logic [2:0]       strb_sync_r;
  vpsp_req_s        req_pipe_r [SYNC_STAGES];
  vpsp_req_s        req_in;
  vpsp_req_s        req_r;
  logic             strb_fall;
  logic             strb_rise;
  logic [PTR_W-1:0] rx_wr_ptr_r;
  logic [PTR_W-1:0] rx_rd_ptr_r;
  logic [PTR_W-1:0] tx_wr_ptr_r;
  logic [PTR_W-1:0] tx_rd_ptr_r;
  logic [NIB_W-1:0] rx_rd_data;
  logic [NIB_W-1:0] tx_rd_data;
  logic             rx_rd_en;
  logic             tx_wr_en;
  logic             tx_fetch;
  logic             tx_inflight_r;
  logic [3:0]       clk_div_r;
  logic [NIB_W-1:0] fifo_mem_r [2];
  logic [1:0]       fifo_cnt_r;
  logic             fifo_wp_r;
  logic             fifo_rp_r;
  logic             fifo_pop;

  // Strobe synchroniser; stage 0 feeds only stage 1
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      strb_sync_r <= 3'h7;
    end else begin
      strb_sync_r <= {strb_sync_r[1:0], i_voice_port_strobe_n}; // [RULE_20]
    end
  end

  // Edges seen only on the settled stages
  assign strb_fall = strb_sync_r[2] & ~strb_sync_r[1];
  assign strb_rise = ~strb_sync_r[2] & strb_sync_r[1];

  // Address, direction and data delayed to line up with the strobe
  assign req_in = '{addr: i_voice_port_addr,
                    rnw:  i_voice_port_read_write,
                    data: i_voice_port_data}; // [RULE_02] [RULE_03]
  always_ff @(posedge i_clk) begin
    req_pipe_r[0] <= req_in;
    req_pipe_r[1] <= req_pipe_r[0];
    req_pipe_r[2] <= req_pipe_r[1];
  end

  // Read request goes to the receive buffer at the strobe fall
  assign rx_rd_en = (st_r == VPSP_IDLE) && strb_fall
                    && req_pipe_r[1].rnw; // [RULE_05]
  // Write lands with the data seen while strobe was still low
  assign tx_wr_en = (st_r == VPSP_ACK_WR) && strb_rise
                    && (req_r.addr == ADDR_VOICE); // [RULE_08]

  // Access state machine; nothing moves without a processor strobe
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_r                   <= VPSP_IDLE;
      req_r                  <= '0;
      o_voice_port_ready_n   <= 1'b1;
      o_voice_port_data_oe_n <= 1'b1;
      o_voice_port_data      <= RD_IDLE_VAL;
    end else begin
      unique case (st_r)
        VPSP_IDLE: begin
          if (strb_fall) begin // [RULE_01]
            req_r <= req_pipe_r[1]; // [RULE_07]
            if (req_pipe_r[1].rnw) begin
              st_r <= VPSP_FETCH;
            end else begin
              o_voice_port_ready_n <= 1'b0; // [RULE_06]
              st_r                 <= VPSP_ACK_WR;
            end
          end
        end
        VPSP_FETCH: begin
          // Other addresses read as zero
          o_voice_port_data <= (req_r.addr == ADDR_VOICE)
                               ? {4'h0, rx_rd_data} : RD_IDLE_VAL;
          o_voice_port_data_oe_n <= 1'b0; // [RULE_04]
          st_r                   <= VPSP_DRIVE;
        end
        VPSP_DRIVE: begin
          // One cycle of settled data covers the setup ahead of ready
          o_voice_port_ready_n <= 1'b0; // [RULE_10]
          st_r                 <= VPSP_ACK_RD;
        end
        VPSP_ACK_RD: begin
          if (strb_rise) begin
            o_voice_port_ready_n   <= 1'b1; // [RULE_09]
            o_voice_port_data_oe_n <= 1'b1; // [RULE_19]
            st_r                   <= VPSP_IDLE;
          end
        end
        VPSP_ACK_WR: begin
          req_r.data <= req_pipe_r[2].data;
          if (strb_rise) begin
            o_voice_port_ready_n <= 1'b1;
            st_r                 <= VPSP_IDLE;
          end
        end
        default: begin
          st_r <= VPSP_IDLE;
        end
      endcase
    end
  end

  // Receive pointers: demodulator fills, processor drains in order
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rx_wr_ptr_r <= PTR_RST;
      rx_rd_ptr_r <= PTR_RST;
    end else begin
      if (i_rx_nib_valid) begin
        rx_wr_ptr_r <= next_ptr(rx_wr_ptr_r);
      end
      if (st_r == VPSP_ACK_RD && strb_rise
          && req_r.addr == ADDR_VOICE) begin
        rx_rd_ptr_r <= next_ptr(rx_rd_ptr_r); // [RULE_16]
      end
    end
  end

  // Transmit write pointer steps itself after every voice write
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      tx_wr_ptr_r <= PTR_RST;
    end else if (tx_wr_en) begin
      tx_wr_ptr_r <= next_ptr(tx_wr_ptr_r); // [RULE_17]
    end
  end

  vpsp_nibble_ram u_rx_ram (
    .i_clk     (i_clk),
    .i_wr_en   (i_rx_nib_valid),
    .i_wr_addr (rx_wr_ptr_r),
    .i_wr_data (i_rx_nib),
    .i_rd_en   (rx_rd_en),
    .i_rd_addr (rx_rd_ptr_r),
    .o_rd_data (rx_rd_data)
  );

  // Low nibble of the bus carries the voice sample
  vpsp_nibble_ram u_tx_ram (
    .i_clk     (i_clk),
    .i_wr_en   (tx_wr_en),
    .i_wr_addr (tx_wr_ptr_r),
    .i_wr_data (req_pipe_r[2].data[NIB_W-1:0]),
    .i_rd_en   (tx_fetch),
    .i_rd_addr (tx_rd_ptr_r),
    .o_rd_data (tx_rd_data)
  );

  // Fetch only when a slot is free, counting the read in flight
  assign tx_fetch = ({1'b0, tx_inflight_r} + fifo_cnt_r) < 2'h2
                    && !(fifo_cnt_r == 2'h1 && tx_inflight_r);
  assign fifo_pop = o_tx_nib_valid && i_tx_nib_ready;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      tx_inflight_r <= 1'b0;
      tx_rd_ptr_r   <= PTR_RST;
    end else begin
      tx_inflight_r <= tx_fetch;
      if (tx_fetch) begin
        tx_rd_ptr_r <= next_ptr(tx_rd_ptr_r);
      end
    end
  end

  // Two-entry buffer; a modulator stall holds back the fetches
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      fifo_cnt_r <= 2'h0;
      fifo_wp_r  <= 1'b0;
      fifo_rp_r  <= 1'b0;
    end else begin
      if (tx_inflight_r) begin
        fifo_mem_r[fifo_wp_r] <= tx_rd_data;
        fifo_wp_r             <= ~fifo_wp_r;
      end
      if (fifo_pop) begin
        fifo_rp_r <= ~fifo_rp_r;
      end
      fifo_cnt_r <= fifo_cnt_r + {1'b0, tx_inflight_r}
                    - {1'b0, fifo_pop};
    end
  end

  // Output stage registered so the modulator sees flop outputs
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_tx_nib_valid <= 1'b0;
      o_tx_nib       <= 4'h0;
    end else begin
      o_tx_nib_valid <= (fifo_cnt_r - {1'b0, fifo_pop}) != 2'h0
                        || tx_inflight_r;
      o_tx_nib       <= (fifo_cnt_r - {1'b0, fifo_pop}) != 2'h0
                        ? fifo_mem_r[fifo_rp_r ^ fifo_pop] : tx_rd_data;
    end
  end

  // Processor clock from the system clock by a divider
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      clk_div_r            <= 4'h0;
      o_voice_proc_clk_out <= 1'b0;
    end else if (clk_div_r == VOICE_PROC_CLK_OUT_HALF - 4'h1) begin
      clk_div_r            <= 4'h0;
      o_voice_proc_clk_out <= ~o_voice_proc_clk_out; // [RULE_14]
    end else begin
      clk_div_r <= clk_div_r + 4'h1;
    end
  end

  // Checks
  sequence rd_start_s;
    st_r == VPSP_IDLE && strb_fall && req_pipe_r[1].rnw;
  endsequence
  sequence wr_start_s;
    st_r == VPSP_IDLE && strb_fall && !req_pipe_r[1].rnw;
  endsequence

  read_ready_time_a: assert property (@(posedge i_clk) disable iff (i_srst)
    rd_start_s |-> ##3 $fell(o_voice_port_ready_n)) // [RULE_05]
    else $error("read ready not low three cycles after strobe");
  data_before_rdy_a: assert property (@(posedge i_clk) disable iff (i_srst)
    $fell(o_voice_port_ready_n) && st_r == VPSP_ACK_RD
    |-> $past(!o_voice_port_data_oe_n)) // [RULE_10]
    else $error("ready fell before read data was driven");
  write_ready_a: assert property (@(posedge i_clk) disable iff (i_srst)
    wr_start_s |=> !o_voice_port_ready_n && o_voice_port_data_oe_n) // [RULE_06]
    else $error("write not acknowledged next cycle");
  drive_read_only_a: assert property (@(posedge i_clk) disable iff (i_srst)
    !o_voice_port_data_oe_n |-> req_r.rnw && st_r != VPSP_IDLE) // [RULE_19]
    else $error("bus driven outside a read");
  idle_ready_high_a: assert property (@(posedge i_clk) disable iff (i_srst)
    st_r == VPSP_IDLE |-> o_voice_port_ready_n) // [RULE_09]
    else $error("ready low while idle");
  no_self_start_a: assert property (@(posedge i_clk) disable iff (i_srst)
    st_r == VPSP_IDLE && !strb_fall |=> st_r == VPSP_IDLE) // [RULE_01]
    else $error("access began without a strobe");
  rx_order_a: assert property (@(posedge i_clk) disable iff (i_srst)
    st_r == VPSP_ACK_RD && strb_rise && req_r.addr == ADDR_VOICE
    |=> rx_rd_ptr_r == next_ptr($past(rx_rd_ptr_r))) // [RULE_16]
    else $error("receive pointer did not step");
  tx_pipe_a: assert property (@(posedge i_clk) disable iff (i_srst)
    tx_wr_en |=> tx_wr_ptr_r == next_ptr($past(tx_wr_ptr_r))) // [RULE_17]
    else $error("transmit pointer did not step");
  ptr_wrap_a: assert property (@(posedge i_clk) disable iff (i_srst)
    st_r == VPSP_ACK_RD && strb_rise && req_r.addr == ADDR_VOICE
    && rx_rd_ptr_r == PTR_LAST |=> rx_rd_ptr_r == PTR_RST) // [RULE_18]
    else $error("receive pointer did not wrap");
  clk_toggle_a: assert property (@(posedge i_clk) disable iff (i_srst)
    $rose(o_voice_proc_clk_out) |=> !o_voice_proc_clk_out) // [RULE_14]
    else $error("clock output high too long");

endmodule

// ===== verification/vpsp_proc_model.sv
// Bus master model standing in for the external voice processor.
// Assumes the bench resolves the shared data wire from both enables.
`timescale 1ns/100ps
module vpsp_proc_model (
  // Clock and device answer
  input  wire logic       i_clk,
  input  wire logic       i_ready_n,
  input  wire logic [7:0] i_bus,
  // Request pins
  output logic [2:0]      o_addr,
  output logic [7:0]      o_data,
  output logic            o_drive,
  output logic            o_strobe_n,
  output logic            o_rnw
);
  // Idle bus: strobe high, nothing driven
  initial begin
    o_addr = 3'h7;
    o_data = 8'h00;
    o_drive = 1'b0;
    o_strobe_n = 1'b1;
    o_rnw = 1'b1;
  end

  // One access; slow adds cycles before strobe release
  task automatic access(input logic rnw, input logic [2:0] a,
                        input logic [7:0] wd, input int slow,
                        output logic [7:0] rd, output logic [7:0] early,
                        output logic ok);
    int n;
    @(negedge i_clk);
    o_addr = a;      // Set up ahead of strobe
    o_rnw = rnw;
    o_drive = !rnw;  // Drive only on writes
    o_data = wd;
    @(negedge i_clk);
    o_strobe_n = 1'b0;
    ok = 1'b0;
    early = 8'hxx;
    // Strobe held until ready falls; reads wait
    for (n = 0; n < 64 && !ok; n++) begin
      @(negedge i_clk);
      ok = (i_ready_n === 1'b0);
      if (!ok) early = i_bus;
    end
    rd = i_bus;
    repeat (slow) @(negedge i_clk);
    o_strobe_n = 1'b1;
    // Address and data kept until ready clears
    for (n = 0; n < 64 && i_ready_n !== 1'b1; n++) @(negedge i_clk);
    if (i_ready_n !== 1'b1) ok = 1'b0;
    @(negedge i_clk);
    o_drive = 1'b0;
    // Idle gap so a write never follows a read at once
    if (rnw) repeat (3) @(negedge i_clk);
  endtask
endmodule

// ===== verification/tb_top.sv
// Self-checking bench for the voice port: bus reads, writes, streams.
// Assumes the processor model drives the bus pins at falling edges.
`timescale 1ns/100ps
module tb_top;
  import vpsp_pkg::*;
  logic       i_clk, i_srst, drive, strobe_n, rnw, oe_n, ready_n;
  logic       clk_out, rx_v, tx_v, tx_rdy, c;
  logic [2:0] addr;
  logic [7:0] pdata, dev_data, bus, idle_r;
  logic [3:0] rx_nib, tx_nib, n4;
  logic [3:0] rxq[$];
  logic [3:0] wbuf[36];
  int         err_count, checked, k, n;

  // Released wire shows a pattern that changes every cycle
  assign bus = !oe_n ? dev_data : drive ? pdata : idle_r;
  always @(posedge i_clk) begin
    idle_r <= i_srst ? 8'ha5 : ~idle_r;
  end

  vpsp_port i_vpsp_port (
    .i_clk(i_clk), .i_srst(i_srst), .i_voice_port_addr(addr),
    .i_voice_port_data(bus), .i_voice_port_strobe_n(strobe_n),
    .i_voice_port_read_write(rnw), .o_voice_port_data(dev_data),
    .o_voice_port_data_oe_n(oe_n), .o_voice_port_ready_n(ready_n),
    .o_voice_proc_clk_out(clk_out), .i_rx_nib_valid(rx_v),
    .i_rx_nib(rx_nib), .o_tx_nib_valid(tx_v), .o_tx_nib(tx_nib),
    .i_tx_nib_ready(tx_rdy));

  vpsp_proc_model i_vpsp_proc_model (
    .i_clk(i_clk), .i_ready_n(ready_n), .i_bus(bus), .o_addr(addr),
    .o_data(pdata), .o_drive(drive), .o_strobe_n(strobe_n),
    .o_rnw(rnw));

  // 25 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Unmapped places read as the idle value
  function automatic logic [7:0] exp_rd(input logic [2:0] a,
                                        input logic [3:0] v);
    return (a == ADDR_VOICE) ? {4'h0, v} : RD_IDLE_VAL;
  endfunction

  // Bus access with a random slow release; a hang ends the run
  task automatic bus_op(input logic r, input logic [2:0] a,
                        input logic [7:0] wd, input logic [7:0] exp);
    logic [7:0] rd, early;
    logic       ok;
    i_vpsp_proc_model.access(r, a, wd, $urandom % 4, rd, early, ok);
    if (!ok) begin
      err_count++;
      end_of_test();
    end
    if (r) begin
      chk("rd_data", exp, rd);
      chk("rd_early", exp, early);
      chk("oe_n_after", 8'h01, {7'h0, oe_n});
    end
  endtask

  // Back-to-back received nibbles, one per cycle
  task automatic push_rx(input int cnt);
    repeat (cnt) begin
      @(negedge i_clk);
      rx_v = 1'b1;
      rx_nib = 4'($urandom);
      rxq.push_back(rx_nib);
    end
    @(negedge i_clk);
    rx_v = 1'b0;
  endtask

  // Hang guard
  initial begin
    #3000000;
    err_count++;
    end_of_test();
  end

  initial begin
    void'($urandom(61366));
    i_srst = 1'b1;
    rx_v = 1'b0;
    rx_nib = 4'h0;
    tx_rdy = 1'b0;
    repeat (10) @(negedge i_clk);
    chk("ready_n_rst", 8'h01, {7'h0, ready_n});
    chk("oe_n_rst", 8'h01, {7'h0, oe_n});
    chk("data_rst", RD_IDLE_VAL, dev_data);
    chk("tx_v_rst", 8'h00, {7'h0, tx_v});
    i_srst = 1'b0;
    // Processor clock toggles every system cycle
    c = clk_out;
    repeat (4) begin
      @(negedge i_clk);
      chk("clk_out", {7'h0, ~c}, {7'h0, clk_out});
      c = clk_out;
    end
    // 60 nibbles through a 36-deep ring, read in arrival order;
    // a long mid-run reset before the last round restarts both pointers
    for (k = 0; k < 5; k++) begin
      if (k == 4) begin
        @(negedge i_clk);
        i_srst = 1'b1;
        repeat (28) @(negedge i_clk);
        chk("ready_n_mid", 8'h01, {7'h0, ready_n});
        chk("clk_out_mid", 8'h00, {7'h0, clk_out});
        i_srst = 1'b0;
      end
      push_rx(12);
      repeat (12) begin
        n4 = rxq.pop_front();
        bus_op(1'b1, ADDR_VOICE, 8'h00, exp_rd(ADDR_VOICE, n4));
      end
    end
    for (k = 1; k < 8; k++) begin
      bus_op(1'b1, 3'(k), 8'h00, exp_rd(3'(k), 4'h0));
    end
    // Fill transmit ring while the modulator stalls; stray writes
    for (k = 0; k < 36; k++) begin
      wbuf[k] = 4'($urandom);
      // Upper nibble is random and must be dropped
      bus_op(1'b0, ADDR_VOICE, {4'($urandom), wbuf[k]}, 8'h00);
      if (k % 9 == 0) begin
        bus_op(1'b0, 3'(k / 9 + 1), 8'($urandom), 8'h00);
      end
    end
    // Drain with random stalls; the first two were fetched before writes
    k = 0;
    for (n = 0; n < 2000 && k < 39; n++) begin
      @(negedge i_clk);
      tx_rdy = 1'($urandom);
      if (tx_rdy && tx_v === 1'b1) begin
        if (k >= 2) begin
          chk("tx_nib", {4'h0, wbuf[k % 36]}, {4'h0, tx_nib});
        end
        k++;
      end
    end
    if (k < 39) err_count++;
    tx_rdy = 1'b0;
    end_of_test();
  end
endmodule
